// file: design/pes_top.sv
// The APB register port and the address map were left to the implementer.
`timescale 1ns/1ps
// Function
// - On dedicated counter overflow write record of GPRs, flags and IP to buffer.
// - After storing the record, reload counter with reset count and keep counting.
// - Raise interrupt once buffer index reaches programmed threshold.
// - Buffer is linear; record index never wraps back to base.
// - Sampling only for execution, front-end and replay event classes.
// - Only counter four of its group can trigger sample records.
// - Identification output flags debug store presence at bit 21.
// - Sampling-absent flag in misc enable register reads clear.
// - Bit 24 of sampling enable register turns sampling on or off.
// - Writable save-area pointer register holds management area address.
// - Sampling interrupt shares one vector with non-precise and branch trace.
// - Entering system management mode disables debug store; stays off there.
// - Machine check disables debug store; reset and init clear it.
// - Debug store keeps working in real address mode.
// - Select bit 0 counts thread 1 at privilege 1, 2 or 3.
// - Select bit 1 counts thread 1 at privilege 0; both bits count all.
// - Bits 2 and 3 do the same for thread 0.
// - Select bit 4 enables micro-op tagging.
// - Select bits 5 to 8 hold the four-bit tag value.
// - Bits 25 to 30 choose event class, bits 9 to 24 the events.
// - Thread-independent events count regardless of thread qualification bits.
module pes_top
    import pes_pkg::*;
#(
    parameter int CNT_W = 32
) (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    // Core side
    input  wire pes_event_t  ev,
    input  wire pes_arch_t   arch,
    input  wire logic        sysmgmt_active,
    input  wire logic        mce_pulse,
    input  wire logic        init_pulse,
    input  wire logic        branch_trace_irq_req,
    input  wire logic        nonprecise_irq_req,
    output logic [31:0]      proc_id_flags,
    output logic             tag_enable,
    output logic [3:0]       tag_value,
    output logic             store_irq,
    // Record memory write port
    output pes_memwr_t       mem_wr,
    input  wire logic        mem_ack
);

    logic [63:0]      esc_r;
    logic [31:0]      sample_en_r;
    logic [31:0]      save_ptr_r;
    logic [31:0]      base_r;
    logic [31:0]      index_r;
    logic [31:0]      absmax_r;
    logic [31:0]      thresh_r;
    logic [CNT_W-1:0] cnt_reset_r;
    logic [CNT_W-1:0] cnt_r;
    logic             sysmgmt_q_r;
    logic             pready_r;
    logic [31:0]      prdata_r;
    logic             pslverr_r;
    logic             store_irq_r;
    logic             tag_en_r;
    logic [3:0]       tag_val_r;
    logic [31:0]      proc_id_r;
    pes_memwr_t       mem_wr_r;
    pes_state_t       state_r;
    pes_state_t       state_nxt;
    logic [3:0]       word_r;
    logic [3:0]       word_nxt;
    logic [REC_WORDS*32-1:0] snap_r;
    logic [REC_WORDS*32-1:0] snap_nxt;

    // APB decode
    logic       acc;
    logic       wr_en;
    logic       mapped;
    logic [31:0] rd_val;

    assign acc    = psel & penable & pready_r;
    assign wr_en  = acc & pwrite & mapped;
    assign mapped = (paddr[1:0] == 2'b00) && (paddr <= OFF_PROC_ID);

    logic w_esc_lo, w_esc_hi, w_en, w_ptr, w_base, w_idx, w_max, w_thr, w_crst, w_cnt;
    assign w_esc_lo = wr_en && paddr == OFF_ESC_LO;
    assign w_esc_hi = wr_en && paddr == OFF_ESC_HI;
    assign w_en     = wr_en && paddr == OFF_SAMPLE_EN;
    assign w_ptr    = wr_en && paddr == OFF_SAVE_PTR;
    assign w_base   = wr_en && paddr == OFF_BUF_BASE;
    assign w_idx    = wr_en && paddr == OFF_BUF_INDEX;
    assign w_max    = wr_en && paddr == OFF_ABS_MAX;
    assign w_thr    = wr_en && paddr == OFF_INT_THRESH;
    assign w_crst   = wr_en && paddr == OFF_CNT_RESET;
    assign w_cnt    = wr_en && paddr == OFF_COUNTER;

    // Event qualification
    logic [5:0]  esc_cls;
    logic [15:0] esc_msk;
    logic        cls_ok;
    logic        thread_ok;
    logic        tag_ok;
    logic        mech_on;
    logic        hit;
    logic        ovf;
    logic        room;
    logic        rec_start;
    logic        rec_done;
    logic        pes_irq;

    assign esc_cls = esc_r[ESC_CLS_MSB:ESC_CLS_LSB];
    assign esc_msk = esc_r[ESC_MSK_MSB:ESC_MSK_LSB];
    // Only the at-retirement classes can reach the dedicated counter
    assign cls_ok  = (ev.cls == CLS_EXEC || ev.cls == CLS_FRONT || ev.cls == CLS_REPLAY)
                     && ev.cls == esc_cls;

    always_comb begin
        if (ev.thr_indep) begin
            thread_ok = 1'b1;
        end else if (ev.thread) begin
            thread_ok = (ev.priv == 2'd0) ? esc_r[ESC_THR1_KERN] : esc_r[ESC_THR1_USER];
        end else begin
            thread_ok = (ev.priv == 2'd0) ? esc_r[ESC_THR0_KERN] : esc_r[ESC_THR0_USER];
        end
    end

    assign tag_ok = !esc_r[ESC_TAG_EN] || |(ev.tag & esc_r[ESC_TAG_MSB:ESC_TAG_LSB]);
    // No processor-mode term here: real address mode samples like any other
    assign mech_on = sample_en_r[SAMPLE_EN_BIT] & ~sysmgmt_active;
    assign hit = ev.valid && ev.ctr == DEDICATED_CTR && cls_ok && thread_ok && tag_ok
                 && |(ev.mask & esc_msk) && mech_on && state_r == PES_IDLE
                 && !init_pulse;
    assign ovf = hit && (cnt_r == {CNT_W{1'b1}});
    // Widened compare so an index near the top of the space cannot wrap
    assign room = ({1'b0, index_r} + {1'b0, REC_BYTES}) <= {1'b0, absmax_r};
    assign rec_start = ovf && room;
    assign rec_done  = state_r == PES_WRITE && mem_ack && word_r == REC_LAST;
    assign pes_irq   = sample_en_r[SAMPLE_EN_BIT] && index_r >= thresh_r;

    // Record sequencer
    always_comb begin
        state_nxt = state_r;
        word_nxt  = word_r;
        snap_nxt  = snap_r;
        if (init_pulse) begin
            state_nxt = PES_IDLE;
            word_nxt  = 4'h0;
        end else if (state_r == PES_IDLE) begin
            if (rec_start) begin
                state_nxt = PES_WRITE;
                word_nxt  = 4'h0;
                snap_nxt  = arch;
            end
        end else if (mem_ack) begin
            if (word_r == REC_LAST) begin
                state_nxt = PES_IDLE;
            end else begin
                word_nxt = word_r + 4'h1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= PES_IDLE;
            word_r  <= 4'h0;
            snap_r  <= '0;
        end else begin
            state_r <= state_nxt;
            word_r  <= word_nxt;
            snap_r  <= snap_nxt;
        end
    end

    // Memory write port: one word held until acknowledged
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mem_wr_r <= '0;
        end else if (state_nxt == PES_WRITE) begin
            mem_wr_r.req  <= 1'b1;
            mem_wr_r.addr <= index_r + {26'h0, word_nxt, 2'b00};
            mem_wr_r.data <= snap_nxt[32*word_nxt +: 32];
        end else begin
            mem_wr_r.req <= 1'b0;
        end
    end

    // Buffer index: records only advance it, never wrap it; init clears it and APB writes load it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            index_r <= WORD_RESET;
        end else if (init_pulse) begin
            index_r <= WORD_RESET;
        end else if (rec_done) begin
            index_r <= index_r + REC_BYTES;
        end else if (w_idx) begin
            index_r <= pwdata;
        end
    end

    // Counter: held at all ones during the record, reloaded when it is stored
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r <= '0;
        end else if (init_pulse) begin
            cnt_r <= '0;
        end else if (rec_done || (ovf && !room)) begin
            cnt_r <= cnt_reset_r;
        end else if (hit && !ovf) begin
            cnt_r <= cnt_r + {{(CNT_W-1){1'b0}}, 1'b1};
        end else if (w_cnt) begin
            cnt_r <= pwdata[CNT_W-1:0];
        end
    end

    // Enable bit: cleared on machine check and on entry to system management mode
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sample_en_r <= WORD_RESET;
            sysmgmt_q_r <= 1'b0;
        end else begin
            sysmgmt_q_r <= sysmgmt_active;
            if (init_pulse || mce_pulse || (sysmgmt_active && !sysmgmt_q_r)) begin
                sample_en_r <= WORD_RESET;
            end else if (w_en) begin
                sample_en_r <= pwdata;
            end
        end
    end

    // Configuration registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            esc_r       <= ESC_RESET;
            save_ptr_r  <= WORD_RESET;
            base_r      <= WORD_RESET;
            absmax_r    <= WORD_RESET;
            thresh_r    <= WORD_RESET;
            cnt_reset_r <= '0;
        end else if (init_pulse) begin
            esc_r       <= ESC_RESET;
            save_ptr_r  <= WORD_RESET;
            base_r      <= WORD_RESET;
            absmax_r    <= WORD_RESET;
            thresh_r    <= WORD_RESET;
            cnt_reset_r <= '0;
        end else begin
            if (w_esc_lo) esc_r[31:0]  <= pwdata;
            if (w_esc_hi) esc_r[63:32] <= pwdata;
            if (w_ptr)    save_ptr_r   <= pwdata;
            if (w_base)   base_r       <= pwdata;
            if (w_max)    absmax_r     <= pwdata;
            if (w_thr)    thresh_r     <= pwdata;
            if (w_crst)   cnt_reset_r  <= pwdata[CNT_W-1:0];
        end
    end

    // Read mux
    always_comb begin
        rd_val = WORD_RESET;
        unique case (paddr)
            OFF_ESC_LO:     rd_val = esc_r[31:0];
            OFF_ESC_HI:     rd_val = esc_r[63:32];
            OFF_SAMPLE_EN:  rd_val = sample_en_r;
            OFF_MISC_EN:    rd_val = WORD_RESET;
            OFF_SAVE_PTR:   rd_val = save_ptr_r;
            OFF_BUF_BASE:   rd_val = base_r;
            OFF_BUF_INDEX:  rd_val = index_r;
            OFF_ABS_MAX:    rd_val = absmax_r;
            OFF_INT_THRESH: rd_val = thresh_r;
            OFF_CNT_RESET:  rd_val = 32'(cnt_reset_r);
            OFF_COUNTER:    rd_val = 32'(cnt_r);
            OFF_STATUS:     rd_val = {28'h0, pes_irq, ~room, sysmgmt_active,
                                      state_r == PES_WRITE};
            OFF_PROC_ID:    rd_val = proc_id_r;
            default:        rd_val = WORD_RESET;
        endcase
    end

    // APB answer: one wait state, data and error registered with pready
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r  <= 1'b0;
            prdata_r  <= WORD_RESET;
            pslverr_r <= 1'b0;
        end else if (psel && penable && !pready_r) begin
            pready_r  <= 1'b1;
            prdata_r  <= pwrite ? WORD_RESET : rd_val;
            pslverr_r <= !mapped;
        end else begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
        end
    end

    // Core-facing outputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            store_irq_r <= 1'b0;
            tag_en_r    <= 1'b0;
            tag_val_r   <= 4'h0;
            proc_id_r   <= PROC_ID_VALUE;
        end else begin
            // One vector serves all three debug store sources
            store_irq_r <= pes_irq | branch_trace_irq_req | nonprecise_irq_req;
            tag_en_r    <= esc_r[ESC_TAG_EN];
            tag_val_r   <= esc_r[ESC_TAG_MSB:ESC_TAG_LSB];
            proc_id_r   <= PROC_ID_VALUE;
        end
    end

    assign pready        = pready_r;
    assign prdata        = prdata_r;
    assign pslverr       = pslverr_r;
    assign store_irq     = store_irq_r;
    assign tag_enable    = tag_en_r;
    assign tag_value     = tag_val_r;
    assign proc_id_flags = proc_id_r;
    assign mem_wr        = mem_wr_r;

    // Checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_rec_last;
        state_r == PES_WRITE && mem_ack && word_r == REC_LAST && !init_pulse;
    endsequence

    property p_rec_start;
        rec_start |=> state_r == PES_WRITE && mem_wr_r.req && mem_wr_r.addr == $past(index_r)
                      && mem_wr_r.data == $past(arch.gpr[0]);
    endproperty
    a_rec_start: assert property (p_rec_start) else $error("record not started");

    property p_reload;
        s_rec_last |=> cnt_r == $past(cnt_reset_r) && state_r == PES_IDLE && !mem_wr_r.req;
    endproperty
    a_reload: assert property (p_reload) else $error("counter not reloaded");

    property p_irq;
        pes_irq |=> store_irq;
    endproperty
    a_irq: assert property (p_irq) else $error("threshold interrupt missing");

    property p_linear;
        !w_idx && !init_pulse |=> index_r >= $past(index_r);
    endproperty
    a_linear: assert property (p_linear) else $error("index moved backwards");

    property p_class;
        ev.valid && !(ev.cls == CLS_EXEC || ev.cls == CLS_FRONT || ev.cls == CLS_REPLAY)
        && state_r == PES_IDLE && !w_cnt && !init_pulse |=> cnt_r == $past(cnt_r);
    endproperty
    a_class: assert property (p_class) else $error("wrong class counted");

    property p_ctr4;
        ev.valid && ev.ctr != DEDICATED_CTR && state_r == PES_IDLE && !w_cnt && !init_pulse
        |=> cnt_r == $past(cnt_r);
    endproperty
    a_ctr4: assert property (p_ctr4) else $error("foreign counter sampled");

    property p_feat;
        proc_id_flags[FEAT_STORE_BIT];
    endproperty
    a_feat: assert property (p_feat) else $error("feature flag clear");

    property p_smm;
        $rose(sysmgmt_active) |=> !sample_en_r[SAMPLE_EN_BIT] ##1 (!rec_start [*2]);
    endproperty
    a_smm: assert property (p_smm) else $error("sampling alive in management mode");

    property p_mce;
        mce_pulse |=> !sample_en_r[SAMPLE_EN_BIT];
    endproperty
    a_mce: assert property (p_mce) else $error("machine check left sampling on");

    property p_limit;
        state_r == PES_IDLE && ovf && !room |=> state_r == PES_IDLE && !mem_wr_r.req;
    endproperty
    a_limit: assert property (p_limit) else $error("record written past limit");

    property p_apb;
        psel && penable && !pready_r |=> pready ##1 !pready;
    endproperty
    a_apb: assert property (p_apb) else $error("apb answer timing");

endmodule : pes_top

// file: design/pes_pkg.sv
package pes_pkg;

    // Register byte offsets on the APB
    localparam logic [7:0] OFF_ESC_LO     = 8'h00;
    localparam logic [7:0] OFF_ESC_HI     = 8'h04;
    localparam logic [7:0] OFF_SAMPLE_EN  = 8'h08;
    localparam logic [7:0] OFF_MISC_EN    = 8'h0C;
    localparam logic [7:0] OFF_SAVE_PTR   = 8'h10;
    localparam logic [7:0] OFF_BUF_BASE   = 8'h14;
    localparam logic [7:0] OFF_BUF_INDEX  = 8'h18;
    localparam logic [7:0] OFF_ABS_MAX    = 8'h1C;
    localparam logic [7:0] OFF_INT_THRESH = 8'h20;
    localparam logic [7:0] OFF_CNT_RESET  = 8'h24;
    localparam logic [7:0] OFF_COUNTER    = 8'h28;
    localparam logic [7:0] OFF_STATUS     = 8'h2C;
    localparam logic [7:0] OFF_PROC_ID    = 8'h30;

    // Event selection control field positions
    localparam int ESC_THR1_USER = 0;
    localparam int ESC_THR1_KERN = 1;
    localparam int ESC_THR0_USER = 2;
    localparam int ESC_THR0_KERN = 3;
    localparam int ESC_TAG_EN    = 4;
    localparam int ESC_TAG_LSB   = 5;
    localparam int ESC_TAG_MSB   = 8;
    localparam int ESC_MSK_LSB   = 9;
    localparam int ESC_MSK_MSB   = 24;
    localparam int ESC_CLS_LSB   = 25;
    localparam int ESC_CLS_MSB   = 30;

    // Other bit positions
    localparam int SAMPLE_EN_BIT  = 24;
    localparam int FEAT_STORE_BIT = 21;
    localparam int ABSENT_BIT     = 12;

    // Reset values
    localparam logic [63:0] ESC_RESET     = 64'h0000_0000_0000_0000;
    localparam logic [31:0] WORD_RESET    = 32'h0000_0000;
    localparam logic [31:0] PROC_ID_VALUE = 32'h0020_0000;

    // Sampling constants
    localparam logic [3:0]  DEDICATED_CTR = 4'h4;
    localparam logic [5:0]  CLS_EXEC      = 6'h0C;
    localparam logic [5:0]  CLS_FRONT     = 6'h08;
    localparam logic [5:0]  CLS_REPLAY    = 6'h09;
    localparam int          REC_WORDS     = 10;
    localparam logic [3:0]  REC_LAST      = 4'h9;
    localparam logic [31:0] REC_BYTES     = 32'h0000_0028;

    typedef enum {PES_IDLE, PES_WRITE} pes_state_t;

    typedef struct packed {
        logic [31:0]       ip;
        logic [31:0]       flags;
        logic [7:0][31:0]  gpr;
    } pes_arch_t;

    typedef struct packed {
        logic        valid;
        logic [3:0]  ctr;
        logic [5:0]  cls;
        logic [15:0] mask;
        logic        thread;
        logic [1:0]  priv;
        logic        thr_indep;
        logic [3:0]  tag;
    } pes_event_t;

    typedef struct packed {
        logic        req;
        logic [31:0] addr;
        logic [31:0] data;
    } pes_memwr_t;

endpackage : pes_pkg

// file: testbench/pes_mem_model.sv
`timescale 1ns/1ps
module pes_mem_model
    import pes_pkg::*;
(
    // Clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // Record write port
    input  wire pes_memwr_t mem_wr,
    input  wire logic       slow,
    output logic            mem_ack
);
    logic [31:0] addr_q[$];
    logic [31:0] data_q[$];

    // Slow mode acks every other cycle so each word must be held
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mem_ack <= 1'b0;
        end else begin
            mem_ack <= mem_wr.req && (!slow || !mem_ack);
            if (mem_wr.req && mem_ack) begin
                addr_q.push_back(mem_wr.addr);
                data_q.push_back(mem_wr.data);
            end
        end
    end
endmodule : pes_mem_model

// file: testbench/precise_event_sampling_bench.sv
`timescale 1ns/1ps
module precise_event_sampling_bench;
    import pes_pkg::*;

    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
    pes_event_t  ev;
    pes_arch_t   arch;
    logic        sysmgmt_active;
    logic        mce_pulse;
    logic        init_pulse;
    logic        bt_irq;
    logic        np_irq;
    logic [31:0] proc_id_flags;
    logic        tag_enable;
    logic [3:0]  tag_value;
    logic        store_irq;
    pes_memwr_t  mem_wr;
    logic        mem_ack;
    logic        slow;
    logic [31:0] rd;
    logic        err;
    int          err_total;
    int          num_checks;
    localparam logic [31:0] IB = 32'h0002_0000;
    localparam logic [31:0] ON = 32'h0100_0000;

    pes_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .ev(ev), .arch(arch), .sysmgmt_active(sysmgmt_active),
        .mce_pulse(mce_pulse), .init_pulse(init_pulse), .branch_trace_irq_req(bt_irq),
        .nonprecise_irq_req(np_irq), .proc_id_flags(proc_id_flags),
        .tag_enable(tag_enable), .tag_value(tag_value), .store_irq(store_irq),
        .mem_wr(mem_wr), .mem_ack(mem_ack));

    pes_mem_model i_mem (.pclk(pclk), .presetn(presetn), .mem_wr(mem_wr), .slow(slow),
        .mem_ack(mem_ack));

    task automatic final_report;
        if (err_total == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : final_report

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask : chk

    task automatic hang(input string msg);
        err_total++;
        $display("CHECK FAILED %0t timeout %s", $time, msg);
        final_report();
    endtask : hang

    // Idle edge after release keeps back-to-back calls from assigning twice in a step
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) hang("apb");
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string msg);
        apb(1'b0, a, 32'h0000_0000);
        chk(rd, exp, msg);
    endtask : rdc

    task automatic fire(input logic [3:0] c, input logic [5:0] cl, input logic t,
                        input logic [1:0] p, input logic ti);
        ev <= '{1'b1, c, cl, 16'h0001, t, p, ti, 4'h1};
        @(posedge pclk);
        ev.valid <= 1'b0;
        @(posedge pclk);
    endtask : fire

    task automatic set_esc(input logic [5:0] cl, input logic [3:0] tb);
        apb(1'b1, OFF_ESC_LO, {1'b0, cl, 16'h0001, 4'h3, 1'b1, tb});
    endtask : set_esc

    task automatic cnt_case(input logic [3:0] c, input logic [5:0] cl, input logic t,
                            input logic [1:0] p, input logic ti, input logic [31:0] exp);
        apb(1'b1, OFF_COUNTER, 32'h0000_0000);
        fire(c, cl, t, p, ti);
        rdc(OFF_COUNTER, exp, "hit count");
    endtask : cnt_case

    task automatic wait_words(input int n);
        int t;
        t = 0;
        while (i_mem.addr_q.size() < n && t < 200) begin
            @(posedge pclk);
            t++;
        end
        if (t >= 200) hang("record");
    endtask : wait_words

    task automatic rec_chk(input logic [31:0] base, input int first);
        logic [31:0] exp;
        for (int k = 0; k < REC_WORDS; k++) begin
            exp = (k < 8) ? arch.gpr[k] : (k == 8) ? arch.flags : arch.ip;
            chk(i_mem.addr_q[first+k], base + 32'(4 * k), "record address");
            chk(i_mem.data_q[first+k], exp, "record word");
        end
    endtask : rec_chk

    task automatic t_ident;
        chk(proc_id_flags, PROC_ID_VALUE, "id flags");
        apb(1'b0, OFF_MISC_EN, 32'h0000_0000);
        chk({31'h0, rd[ABSENT_BIT]}, 32'h0, "absent flag");
        apb(1'b0, 8'h34, 32'h0000_0000);
        chk({31'h0, err}, 32'h1, "unmapped error");
        apb(1'b1, OFF_SAVE_PTR, 32'h0008_1000);
        rdc(OFF_SAVE_PTR, 32'h0008_1000, "save pointer");
        set_esc(CLS_EXEC, 4'h4);
        rdc(OFF_ESC_LO, {1'b0, CLS_EXEC, 16'h0001, 4'h3, 1'b1, 4'h4}, "select");
        chk({31'h0, tag_enable}, 32'h1, "tag enable");
        chk({28'h0, tag_value}, 32'h3, "tag value");
    endtask : t_ident

    task automatic t_count;
        // The counter only advances while sampling is enabled
        apb(1'b1, OFF_SAMPLE_EN, ON);
        cnt_case(4'h4, CLS_EXEC, 1'b0, 2'h3, 1'b0, 32'h1);
        cnt_case(4'h4, CLS_EXEC, 1'b0, 2'h0, 1'b0, 32'h0);
        cnt_case(4'h4, CLS_EXEC, 1'b1, 2'h3, 1'b0, 32'h0);
        cnt_case(4'h4, CLS_EXEC, 1'b1, 2'h3, 1'b1, 32'h1);
        cnt_case(4'h5, CLS_EXEC, 1'b0, 2'h3, 1'b0, 32'h0);
        cnt_case(4'h4, CLS_FRONT, 1'b0, 2'h3, 1'b0, 32'h0);
        set_esc(CLS_EXEC, 4'h3);
        cnt_case(4'h4, CLS_EXEC, 1'b1, 2'h0, 1'b0, 32'h1);
        cnt_case(4'h4, CLS_EXEC, 1'b1, 2'h2, 1'b0, 32'h1);
        cnt_case(4'h4, CLS_EXEC, 1'b0, 2'h0, 1'b0, 32'h0);
        set_esc(6'h01, 4'hF);
        cnt_case(4'h4, 6'h01, 1'b0, 2'h3, 1'b0, 32'h0);
        set_esc(CLS_REPLAY, 4'hF);
        cnt_case(4'h4, CLS_REPLAY, 1'b0, 2'h3, 1'b0, 32'h1);
        set_esc(CLS_FRONT, 4'hF);
        cnt_case(4'h4, CLS_FRONT, 1'b0, 2'h3, 1'b0, 32'h1);
    endtask : t_count

    task automatic t_record;
        apb(1'b1, OFF_BUF_BASE, IB);
        apb(1'b1, OFF_BUF_INDEX, IB);
        apb(1'b1, OFF_ABS_MAX, IB + 32'd119);
        apb(1'b1, OFF_INT_THRESH, IB + 32'd80);
        apb(1'b1, OFF_CNT_RESET, 32'hFFFF_FFFF);
        apb(1'b1, OFF_SAMPLE_EN, ON);
        set_esc(CLS_EXEC, 4'hF);
        apb(1'b1, OFF_COUNTER, 32'hFFFF_FFFF);
        fire(4'h4, CLS_EXEC, 1'b0, 2'h3, 1'b0);
        wait_words(10);
        rec_chk(IB, 0);
        rdc(OFF_BUF_INDEX, IB + 32'd40, "index step");
        rdc(OFF_COUNTER, 32'hFFFF_FFFF, "reload");
        chk({31'h0, store_irq}, 32'h0, "irq early");
        slow <= 1'b1;
        fire(4'h4, CLS_EXEC, 1'b0, 2'h3, 1'b0);
        wait_words(20);
        rec_chk(IB + 32'd40, 10);
        rdc(OFF_BUF_INDEX, IB + 32'd80, "index step");
        chk({31'h0, store_irq}, 32'h1, "irq at threshold");
        apb(1'b1, OFF_CNT_RESET, 32'hFFFF_FFF0);
        apb(1'b1, OFF_COUNTER, 32'hFFFF_FFFF);
        fire(4'h4, CLS_EXEC, 1'b0, 2'h3, 1'b0);
        repeat (30) @(posedge pclk);
        chk(32'(i_mem.addr_q.size()), 32'd20, "write past limit");
        rdc(OFF_BUF_INDEX, IB + 32'd80, "index held");
        rdc(OFF_COUNTER, 32'hFFFF_FFF0, "reload no room");
    endtask : t_record

    task automatic t_disable;
        apb(1'b1, OFF_SAMPLE_EN, 32'h0000_0000);
        apb(1'b1, OFF_BUF_INDEX, IB);
        apb(1'b1, OFF_COUNTER, 32'hFFFF_FFFF);
        chk({31'h0, store_irq}, 32'h0, "irq off");
        fire(4'h4, CLS_EXEC, 1'b0, 2'h3, 1'b0);
        repeat (30) @(posedge pclk);
        chk(32'(i_mem.addr_q.size()), 32'd20, "record while off");
        bt_irq <= 1'b1;
        repeat (3) @(posedge pclk);
        chk({31'h0, store_irq}, 32'h1, "shared vector");
        bt_irq <= 1'b0;
        np_irq <= 1'b1;
        repeat (3) @(posedge pclk);
        chk({31'h0, store_irq}, 32'h1, "shared vector");
        np_irq <= 1'b0;
        apb(1'b1, OFF_SAMPLE_EN, ON);
        sysmgmt_active <= 1'b1;
        repeat (3) @(posedge pclk);
        rdc(OFF_SAMPLE_EN, 32'h0000_0000, "mode entry");
        apb(1'b1, OFF_SAMPLE_EN, ON);
        apb(1'b1, OFF_COUNTER, 32'hFFFF_FFFF);
        fire(4'h4, CLS_EXEC, 1'b0, 2'h3, 1'b0);
        repeat (30) @(posedge pclk);
        chk(32'(i_mem.addr_q.size()), 32'd20, "record in mgmt mode");
        sysmgmt_active <= 1'b0;
        apb(1'b1, OFF_SAMPLE_EN, ON);
        mce_pulse <= 1'b1;
        @(posedge pclk);
        mce_pulse <= 1'b0;
        rdc(OFF_SAMPLE_EN, 32'h0000_0000, "machine check");
        init_pulse <= 1'b1;
        @(posedge pclk);
        init_pulse <= 1'b0;
        @(posedge pclk);
        rdc(OFF_SAVE_PTR, 32'h0000_0000, "init clears");
        rdc(OFF_BUF_INDEX, 32'h0000_0000, "init clears");
    endtask : t_disable

    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end

    initial begin
        err_total = 0;
        num_checks = 0;
        presetn = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        ev = '0;
        for (int k = 0; k < 8; k++) arch.gpr[k] = 32'hA5A5_0000 | 32'(k);
        arch.flags = 32'h0000_0246;
        arch.ip = 32'h0040_1000;
        {sysmgmt_active, mce_pulse, init_pulse, bt_irq, np_irq, slow} = '0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_ident();
        t_count();
        t_record();
        t_disable();
        final_report();
    end
endmodule : precise_event_sampling_bench
